/* File: hdl/gpc_pkg.sv */
// constants, types and register map of the gpio port control block
package gpc_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int unsigned NUM_PINS = 8;
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned SYNC_STAGES = 2;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [2:0] OFS_PIN_DIRECTION = 3'h0;
  localparam logic [2:0] OFS_PIN_OUTPUT_LATCH = 3'h1;
  localparam logic [2:0] OFS_PIN_INPUT_LEVEL = 3'h2;
  localparam logic [2:0] OFS_PIN_MODE_SELECT = 3'h3;
  localparam logic [2:0] OFS_OUTPUT_TYPE_LOW = 3'h4;
  localparam logic [2:0] OFS_OUTPUT_TYPE_HIGH = 3'h5;
  localparam logic [2:0] OFS_PULLUP_CONTROL = 3'h6;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_PIN_DIRECTION = 8'h00;
  localparam logic [7:0] RST_PIN_OUTPUT_LATCH = 8'h00;
  localparam logic [7:0] RST_PIN_MODE_SELECT = 8'h00;
  localparam logic [7:0] RST_OUTPUT_TYPE = 8'h00;
  localparam logic [7:0] RST_PULLUP_CONTROL = 8'h00;
  localparam logic [7:0] READ_IDLE = 8'h00;

  // ----------------------------------------------------------------
  // field layout of the output type registers
  // ----------------------------------------------------------------
  localparam int unsigned TYPE_PINS_PER_REG = 4;
  localparam int unsigned TYPE_FIELD_STRIDE = 2;
  localparam int unsigned TYPE_PIN1_N_BIT = 2;
  localparam int unsigned TYPE_PIN1_P_BIT = 3;
  localparam logic [7:0] TYPE_WMASK_PLAIN = 8'h55;
  localparam logic [7:0] TYPE_WMASK_PORT_E_LOW = 8'h5d;

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  localparam logic DIR_INPUT = 1'b0;
  localparam logic DIR_OUTPUT = 1'b1;
  localparam logic MODE_GENERAL = 1'b0;
  localparam logic MODE_PERIPHERAL = 1'b1;

  typedef enum logic [1:0] {
    GPC_CMOS = 2'h0,
    GPC_N_OPEN = 2'h1,
    GPC_P_OPEN = 2'h2,
    GPC_NO_DRIVE = 2'h3
  } gpc_drive_e;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } gpc_bus_req_s;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } gpc_drive_s;

endpackage : gpc_pkg

/* File: hdl/gpc_port_control.sv */
// eight pin general purpose port: registers, pin drive and input sampling
//
// Summary of operation
// - eight direction bits, one per pin, each choosing input or output for its pin in general mode; a peripheral pin follows periph_oe.
// - eight output latch bits hold the level driven onto each general mode pin that is an output; a peripheral pin drives periph_out.
// - eight input level bits let software read the present state of every pin.
// - eight mode bits, one per pin, each choosing general or peripheral use of its pin alone.
// - eight pull-up bits switch the internal pull-up of each undriven pin on or off; a pin while driven keeps its pull-up off.
// - on an ordinary port pin 1 type bit 2 gives push-pull when 0 and n-channel open drain when 1.
// - on an ordinary port pin 1 type bit 3 always reads zero and software writes only zero.
// - on port e pin 1 the two bit type means 00 cmos, 01 n open drain, 10 p open drain, 11 unused.
// - the upper type register keeps pins 4 to 7 in bits 0, 2, 4 and 6.

`timescale 1ns/10ps
`default_nettype none

module gpc_port_control #(
  parameter bit IS_PORT_E = 1'b0
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire gpc_pkg::gpc_bus_req_s bus_req,
  output logic [7:0] rd_data,
  input wire logic [7:0] pin_i,
  output logic [7:0] pin_o,
  output logic [7:0] pin_oe,
  output logic [7:0] pullup_en,
  input wire logic [7:0] periph_out,
  input wire logic [7:0] periph_oe,
  output logic [7:0] periph_in
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------

  // two bit output type of one pin out of the two type registers
  function automatic logic [1:0] type_field(
    input logic [7:0] low,
    input logic [7:0] high,
    input int unsigned pin
  );
    logic [7:0] reg_sel;
    int unsigned base;
    reg_sel = (pin < gpc_pkg::TYPE_PINS_PER_REG) ? low : high;
    base = (pin % gpc_pkg::TYPE_PINS_PER_REG) * gpc_pkg::TYPE_FIELD_STRIDE;
    type_field = {reg_sel[base + 1], reg_sel[base]};
  endfunction : type_field

  // drive of one pin from its type, data and wish to drive
  function automatic logic [1:0] pin_drive(
    input logic [1:0] kind,
    input logic data,
    input logic drive
  );
    logic oe;
    logic lvl;
    oe = 1'b0;
    lvl = data;
    if (drive) begin
      unique case (gpc_pkg::gpc_drive_e'(kind))
        gpc_pkg::GPC_CMOS: begin
          oe = 1'b1;
        end
        gpc_pkg::GPC_N_OPEN: begin
          oe = ~data;
        end
        gpc_pkg::GPC_P_OPEN: begin
          oe = data;
        end
        gpc_pkg::GPC_NO_DRIVE: begin
          oe = 1'b0;
        end
      endcase
    end
    pin_drive = {oe, lvl};
  endfunction : pin_drive

  // ----------------------------------------------------------------
  // registers and wires
  // ----------------------------------------------------------------
  logic [7:0] sync1_q;
  logic [7:0] sync2_q;
  logic [7:0] direction_q;
  logic [7:0] direction_d;
  logic [7:0] latch_q;
  logic [7:0] latch_d;
  logic [7:0] mode_q;
  logic [7:0] mode_d;
  logic [7:0] type_low_q;
  logic [7:0] type_low_d;
  logic [7:0] type_high_q;
  logic [7:0] type_high_d;
  logic [7:0] pullup_q;
  logic [7:0] pullup_d;
  logic [7:0] rd_data_q;
  logic [7:0] rd_data_d;
  logic [7:0] pin_o_q;
  logic [7:0] pin_oe_q;
  logic [7:0] pullup_en_q;
  logic [7:0] periph_in_q;
  wire gpc_pkg::gpc_drive_s drive_d;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  wire logic wr_any;
  wire logic hit_direction;
  wire logic hit_latch;
  wire logic hit_mode;
  wire logic hit_type_low;
  wire logic hit_type_high;
  wire logic hit_pullup;
  wire logic [7:0] type_low_wmask;

  assign wr_any = bus_req.wr & ce;
  assign hit_direction = wr_any & (bus_req.addr == gpc_pkg::OFS_PIN_DIRECTION);
  assign hit_latch = wr_any & (bus_req.addr == gpc_pkg::OFS_PIN_OUTPUT_LATCH);
  assign hit_mode = wr_any & (bus_req.addr == gpc_pkg::OFS_PIN_MODE_SELECT);
  assign hit_type_low = wr_any & (bus_req.addr == gpc_pkg::OFS_OUTPUT_TYPE_LOW);
  assign hit_type_high = wr_any & (bus_req.addr == gpc_pkg::OFS_OUTPUT_TYPE_HIGH);
  assign hit_pullup = wr_any & (bus_req.addr == gpc_pkg::OFS_PULLUP_CONTROL);

  // only port e keeps the p-channel bit of pin 1
  assign type_low_wmask = IS_PORT_E ? gpc_pkg::TYPE_WMASK_PORT_E_LOW
                                    : gpc_pkg::TYPE_WMASK_PLAIN;

  // ----------------------------------------------------------------
  // next register values
  // ----------------------------------------------------------------
  assign direction_d = hit_direction ? bus_req.wdata : direction_q;
  assign latch_d = hit_latch ? bus_req.wdata : latch_q;
  assign mode_d = hit_mode ? bus_req.wdata : mode_q;
  assign type_low_d = hit_type_low ? (bus_req.wdata & type_low_wmask)
                                   : type_low_q;
  assign type_high_d = hit_type_high ? (bus_req.wdata & gpc_pkg::TYPE_WMASK_PLAIN)
                                     : type_high_q;
  assign pullup_d = hit_pullup ? bus_req.wdata : pullup_q;

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  always_comb begin
    rd_data_d = gpc_pkg::READ_IDLE;
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        gpc_pkg::OFS_PIN_DIRECTION: begin
          rd_data_d = direction_q;
        end
        gpc_pkg::OFS_PIN_OUTPUT_LATCH: begin
          rd_data_d = latch_q;
        end
        gpc_pkg::OFS_PIN_INPUT_LEVEL: begin
          rd_data_d = sync2_q;
        end
        gpc_pkg::OFS_PIN_MODE_SELECT: begin
          rd_data_d = mode_q;
        end
        gpc_pkg::OFS_OUTPUT_TYPE_LOW: begin
          rd_data_d = type_low_q;
        end
        gpc_pkg::OFS_OUTPUT_TYPE_HIGH: begin
          rd_data_d = type_high_q;
        end
        gpc_pkg::OFS_PULLUP_CONTROL: begin
          rd_data_d = pullup_q;
        end
        default: begin
          rd_data_d = gpc_pkg::READ_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pin drive decode
  // ----------------------------------------------------------------
  for (genvar p = 0; p < gpc_pkg::NUM_PINS; p++) begin : g_pin
    wire logic [1:0] kind;
    wire logic periph_sel;
    wire logic want_drive;
    wire logic data;
    wire logic [1:0] drv;

    assign kind = type_field(type_low_q, type_high_q, p);
    assign periph_sel = (mode_q[p] == gpc_pkg::MODE_PERIPHERAL);
    assign want_drive = periph_sel ? periph_oe[p]
                                   : (direction_q[p] == gpc_pkg::DIR_OUTPUT);
    assign data = periph_sel ? periph_out[p] : latch_q[p];
    assign drv = pin_drive(kind, data, want_drive);
    assign drive_d.oe[p] = drv[1];
    assign drive_d.out[p] = drv[0];
  end

  // ----------------------------------------------------------------
  // pin input synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      sync1_q <= 8'h00;
    end else if (ce) begin
      sync1_q <= pin_i;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      sync2_q <= 8'h00;
    end else if (ce) begin
      sync2_q <= sync1_q;
    end
  end

  // ----------------------------------------------------------------
  // software registers: direction
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      direction_q <= gpc_pkg::RST_PIN_DIRECTION;
    end else if (ce) begin
      direction_q <= direction_d;
    end
  end

  // ----------------------------------------------------------------
  // output latch
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      latch_q <= gpc_pkg::RST_PIN_OUTPUT_LATCH;
    end else if (ce) begin
      latch_q <= latch_d;
    end
  end

  // ----------------------------------------------------------------
  // mode select
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      mode_q <= gpc_pkg::RST_PIN_MODE_SELECT;
    end else if (ce) begin
      mode_q <= mode_d;
    end
  end

  // ----------------------------------------------------------------
  // output type, pins 0 to 3
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      type_low_q <= gpc_pkg::RST_OUTPUT_TYPE;
    end else if (ce) begin
      type_low_q <= type_low_d;
    end
  end

  // ----------------------------------------------------------------
  // output type, pins 4 to 7
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      type_high_q <= gpc_pkg::RST_OUTPUT_TYPE;
    end else if (ce) begin
      type_high_q <= type_high_d;
    end
  end

  // ----------------------------------------------------------------
  // pull-up control
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      pullup_q <= gpc_pkg::RST_PULLUP_CONTROL;
    end else if (ce) begin
      pullup_q <= pullup_d;
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      rd_data_q <= gpc_pkg::READ_IDLE;
    end else if (ce) begin
      rd_data_q <= rd_data_d;
    end
  end

  // ----------------------------------------------------------------
  // pin side outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      pin_o_q <= 8'h00;
    end else if (ce) begin
      pin_o_q <= drive_d.out;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pin_oe_q <= 8'h00;
    end else if (ce) begin
      pin_oe_q <= drive_d.oe;
    end
  end

  // ----------------------------------------------------------------
  // pull-up enable and peripheral input
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      pullup_en_q <= 8'h00;
    end else if (ce) begin
      pullup_en_q <= pullup_q & ~drive_d.oe;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      periph_in_q <= 8'h00;
    end else if (ce) begin
      periph_in_q <= sync2_q;
    end
  end

  // ----------------------------------------------------------------
  // port outputs
  // ----------------------------------------------------------------
  assign rd_data = rd_data_q;
  assign pin_o = pin_o_q;
  assign pin_oe = pin_oe_q;
  assign pullup_en = pullup_en_q;
  assign periph_in = periph_in_q;

endmodule : gpc_port_control

`default_nettype wire

/* File: verif/gpc_board_model.sv */
// board circuitry on the eight port pins
`timescale 1ns/10ps
`default_nettype none
module gpc_board_model (
  input wire logic clock,
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pullup_en,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] pin_i
);
  // ----------------
  // pin levels
  // ----------------
  logic float_q = 1'b0;
  always @(posedge clock) float_q <= !float_q;
  wire logic [7:0] idle = pullup_en | {8{float_q}};
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & ((ext_en & ext_val) | (~ext_en & idle)));
endmodule : gpc_board_model
`default_nettype wire

/* File: verif/gpc_port_checker.sv */
// port assertions of the gpio port control block
`timescale 1ns/10ps
`default_nettype none
module gpc_port_checker #(
  parameter bit IS_PORT_E = 1'b0
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire gpc_pkg::gpc_bus_req_s bus_req,
  input wire logic [7:0] rd_data,
  input wire logic [7:0] pin_i,
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pullup_en,
  input wire logic [7:0] periph_out,
  input wire logic [7:0] periph_oe,
  input wire logic [7:0] periph_in
);
  // ----------------
  // helper logic
  // ----------------
  localparam logic [7:0] LOW_MASK = IS_PORT_E ? 8'h5d : 8'h55;
  logic [1:0] run_q;
  always_ff @(posedge clock) begin
    if (rst || !ce) run_q <= 2'h0;
    else if (run_q != 2'h3) run_q <= run_q + 2'h1;
  end
  // ----------------
  // properties
  // ----------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  sequence s_rd(logic [2:0] a);
    ce && bus_req.rd && bus_req.addr == a;
  endsequence
  sequence s_quiet;
    (ce && !bus_req.wr && $stable(periph_oe) && $stable(periph_out)) [*3];
  endsequence
  property p_rd_zero;
    $past(ce) && !$past(bus_req.rd) |-> rd_data == 8'h00;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("read data outside slot");
  property p_rst_out;
    $past(rst) && $past(ce) |-> (pin_oe | pin_o | pullup_en | rd_data) == 8'h00;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("outputs not cleared");
  property p_pull_drv;
    (pullup_en & pin_oe) == 8'h00;
  endproperty
  a_pull_drv: assert property (p_pull_drv) else $error("pull-up on driven pin");
  property p_sync;
    run_q == 2'h3 |-> periph_in == $past(pin_i, 3);
  endproperty
  a_sync: assert property (p_sync) else $error("input sync delay wrong");
  property p_quiet;
    s_quiet |-> $stable(pin_oe) && $stable(pin_o);
  endproperty
  a_quiet: assert property (p_quiet) else $error("pin moved unprompted");
  property p_in_read;
    s_rd(3'h2) |=> rd_data == periph_in;
  endproperty
  a_in_read: assert property (p_in_read) else $error("input level read wrong");
  property p_unmapped;
    s_rd(3'h7) |=> rd_data == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_type_low;
    s_rd(3'h4) |=> (rd_data & ~LOW_MASK) == 8'h00;
  endproperty
  a_type_low: assert property (p_type_low) else $error("low type bits wrong");
  property p_type_high;
    s_rd(3'h5) |=> (rd_data & 8'haa) == 8'h00;
  endproperty
  a_type_high: assert property (p_type_high) else $error("high type bits wrong");
endmodule : gpc_port_checker
bind gpc_port_control gpc_port_checker #(.IS_PORT_E(IS_PORT_E)) u_chk (
  .clock(clock), .rst(rst), .ce(ce), .bus_req(bus_req), .rd_data(rd_data),
  .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe), .pullup_en(pullup_en),
  .periph_out(periph_out), .periph_oe(periph_oe), .periph_in(periph_in)
);
`default_nettype wire

/* File: verif/tb_gpio_port_control.sv */
// self-checking bench of the gpio port control block
`timescale 1ns/10ps
`default_nettype none
module tb_gpio_port_control;
  // ----------------
  // signals
  // ----------------
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  gpc_pkg::gpc_bus_req_s bus_req = '0;
  logic [7:0] rd_data, pin_i, pin_o, pin_oe, pullup_en, periph_in, seen;
  logic [7:0] periph_out = 8'h00;
  logic [7:0] periph_oe = 8'h00;
  logic [7:0] ext_en = 8'h00;
  logic [7:0] ext_val = 8'h00;
  logic [7:0] rd_data_e, pin_o_e, pin_oe_e;
  logic sel_e = 1'b0;
  int n_mismatch = 0;
  int n_checks = 0;
  typedef struct {logic wr; logic [2:0] addr; logic [7:0] data; logic [7:0] exp;} gpc_row_s;
  gpc_row_s rows[13] = '{'{1'b0, 3'h0, 8'h00, 8'h00}, '{1'b0, 3'h1, 8'h00, 8'h00},
    '{1'b0, 3'h3, 8'h00, 8'h00}, '{1'b0, 3'h4, 8'h00, 8'h00}, '{1'b0, 3'h5, 8'h00, 8'h00},
    '{1'b0, 3'h6, 8'h00, 8'h00}, '{1'b1, 3'h0, 8'hff, 8'hff}, '{1'b1, 3'h1, 8'ha5, 8'ha5},
    '{1'b1, 3'h3, 8'h3c, 8'h3c}, '{1'b1, 3'h6, 8'h5a, 8'h5a}, '{1'b1, 3'h4, 8'hf7, 8'h55},
    '{1'b1, 3'h5, 8'hff, 8'h55}, '{1'b1, 3'h7, 8'hff, 8'h00}};
  gpc_port_control #(.IS_PORT_E(1'b0)) DUT (
    .clock(clock), .rst(rst), .ce(ce),
    .bus_req(sel_e ? gpc_pkg::gpc_bus_req_s'('0) : bus_req), .rd_data(rd_data),
    .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe), .pullup_en(pullup_en),
    .periph_out(periph_out), .periph_oe(periph_oe), .periph_in(periph_in)
  );
  gpc_port_control #(.IS_PORT_E(1'b1)) DUT_E (
    .clock(clock), .rst(rst), .ce(ce),
    .bus_req(sel_e ? bus_req : gpc_pkg::gpc_bus_req_s'('0)), .rd_data(rd_data_e),
    .pin_i(pin_i), .pin_o(pin_o_e), .pin_oe(pin_oe_e), .pullup_en(),
    .periph_out(periph_out), .periph_oe(periph_oe), .periph_in()
  );
  gpc_board_model board (
    .clock(clock), .pin_o(pin_o), .pin_oe(pin_oe), .pullup_en(pullup_en),
    .ext_en(ext_en), .ext_val(ext_val), .pin_i(pin_i)
  );
  // ----------------
  // tasks
  // ----------------
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus_req.wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [2:0] a);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus_req.rd <= 1'b0;
    @(negedge clock);
    seen = sel_e ? rd_data_e : rd_data;
  endtask : rd_reg
  task automatic settle();
    repeat (4) @(negedge clock);
  endtask : settle
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results
  // ----------------
  // stimulus
  // ----------------
  initial begin
    forever #4 clock = ~clock;
  end
  initial begin
    repeat (4000) @(posedge clock);
    n_mismatch++;
    $display("ERROR t=%0t watchdog expired", $time);
    results();
  end
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].wr) wr_reg(rows[i].addr, rows[i].data);
      rd_reg(rows[i].addr);
      chk(seen, rows[i].exp);
    end
    $display("register table done");
    wr_reg(3'h4, 8'h00);
    wr_reg(3'h5, 8'h00);
    wr_reg(3'h3, 8'h00);
    settle();
    chk(pin_oe, 8'hff);
    chk(pin_o, 8'ha5);
    chk(pullup_en, 8'h00);
    rd_reg(3'h2);
    chk(seen, 8'ha5);
    $display("pin drive done");
    wr_reg(3'h0, 8'h00);
    ext_en <= 8'ha5;
    ext_val <= 8'h81;
    settle();
    chk(pin_oe, 8'h00);
    chk(pullup_en, 8'h5a);
    rd_reg(3'h2);
    chk(seen, 8'hdb);
    chk(periph_in, 8'hdb);
    wr_reg(3'h2, 8'h00);
    rd_reg(3'h2);
    chk(seen, 8'hdb);
    $display("input level done");
    ext_en <= 8'h00;
    wr_reg(3'h4, 8'h04);
    wr_reg(3'h5, 8'h01);
    wr_reg(3'h1, 8'hb7);
    wr_reg(3'h0, 8'hff);
    settle();
    chk(pin_oe, 8'hed);
    chk(pullup_en, 8'h12);
    $display("output type done");
    @(posedge clock);
    periph_oe <= 8'hff;
    periph_out <= 8'h0d;
    wr_reg(3'h0, 8'h00);
    wr_reg(3'h3, 8'h03);
    settle();
    chk(pin_oe, 8'h03);
    chk(pin_o & 8'h03, 8'h01);
    $display("pin mode done");
    @(posedge clock);
    ce <= 1'b0;
    wr_reg(3'h0, 8'hff);
    ce <= 1'b1;
    rd_reg(3'h0);
    chk(seen, 8'h00);
    $display("clock enable done");
    @(posedge clock);
    sel_e <= 1'b1;
    wr_reg(3'h0, 8'h02);
    wr_reg(3'h4, 8'h08);
    settle();
    chk(pin_oe_e, 8'h00);
    rd_reg(3'h4);
    chk(seen, 8'h08);
    wr_reg(3'h1, 8'h02);
    settle();
    chk(pin_oe_e, 8'h02);
    chk(pin_o_e, 8'h02);
    wr_reg(3'h4, 8'h04);
    settle();
    chk(pin_oe_e, 8'h00);
    $display("port e done");
    results();
  end
endmodule : tb_gpio_port_control
`default_nettype wire
